// ==== rtl/mbcfg_regs.svh ====
`ifndef MBCFG_REGS_SVH
`define MBCFG_REGS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define MBCFG_ADDR_SERVER  16'h1130
`define MBCFG_ADDR_BAUD    16'h1131
`define MBCFG_ADDR_PARITY  16'h1132
`define MBCFG_ADDR_STOP    16'h1133
`define MBCFG_ADDR_WIND    16'h1194
`define MBCFG_ADDR_HUMTMP  16'h1195
`define MBCFG_ADDR_TILT    16'h1196

// ----------------------------------------------------------------
// register indices in the bank
// ----------------------------------------------------------------
`define MBCFG_IDX_SERVER   3'h0
`define MBCFG_IDX_BAUD     3'h1
`define MBCFG_IDX_PARITY   3'h2
`define MBCFG_IDX_STOP     3'h3
`define MBCFG_IDX_WIND     3'h4
`define MBCFG_IDX_HUMTMP   3'h5
`define MBCFG_IDX_TILT     3'h6
`define MBCFG_IDX_NONE     3'h7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MBCFG_RST_SERVER   16'h0001
`define MBCFG_RST_BAUD     16'h0001
`define MBCFG_RST_PARITY   16'h0002
`define MBCFG_RST_STOP     16'h0001
`define MBCFG_RST_WIND     16'h0003
`define MBCFG_RST_HUMTMP   16'h000A
`define MBCFG_RST_TILT     16'h003C

// ----------------------------------------------------------------
// legal ranges and encodings
// ----------------------------------------------------------------
`define MBCFG_SERVER_MIN   16'h0001
`define MBCFG_SERVER_MAX   16'h00F7
`define MBCFG_BAUD_MAX     16'h0001
`define MBCFG_PARITY_MAX   16'h0002
`define MBCFG_STOP_MIN     16'h0001
`define MBCFG_STOP_MAX     16'h0002
`define MBCFG_IVL_MIN      16'h0001
`define MBCFG_IVL_MAX      16'h0078

// ----------------------------------------------------------------
// function and exception codes
// ----------------------------------------------------------------
`define MBCFG_FC_RD_HOLD   8'h03
`define MBCFG_FC_RD_INPUT  8'h04
`define MBCFG_FC_WR_SINGLE 8'h06
`define MBCFG_FC_EXC_BIT   8'h80
`define MBCFG_EXC_FUNC     8'h01
`define MBCFG_EXC_ADDR     8'h02
`define MBCFG_EXC_VALUE    8'h03

// ----------------------------------------------------------------
// wind failure sentinels, single-precision float
// ----------------------------------------------------------------
`define MBCFG_WIND_OK      2'h0
`define MBCFG_WIND_F9990   2'h1
`define MBCFG_WIND_F9999   2'h2
`define MBCFG_WIND_F7999   2'h3
`define MBCFG_SENT_9990    32'hC61C1800
`define MBCFG_SENT_9999    32'hC61C3C00
`define MBCFG_SENT_7999    32'hC5F9F800

`endif

// ==== rtl/mbcfg_pkg.sv ====
`default_nettype none

package mbcfg_pkg;

  // ----------------------------------------------------------------
  // request and answer carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] data;
  } mbcfg_req_s;

  typedef struct packed {
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] data;
  } mbcfg_rsp_s;

  // settings the serial link runs under
  typedef struct packed {
    logic [7:0] server_address;
    logic       baud_select;
    logic [1:0] parity_format;
    logic [1:0] stop_bit_format;
  } mbcfg_serial_s;

  typedef struct packed {
    logic [15:0] wind_interval;
    logic [15:0] humidity_temp_interval;
    logic [15:0] tilt_interval;
  } mbcfg_interval_s;

  typedef enum logic {
    MBCFG_ST_LIVE = 1'b0,
    MBCFG_ST_SWAP = 1'b1
  } mbcfg_state_e;

endpackage

`default_nettype wire

// ==== rtl/mbcfg_holding_regs.sv ====
`include "mbcfg_regs.svh"
`default_nettype none

module mbcfg_holding_regs #(
  parameter logic [15:0] SERVER_MAX = `MBCFG_SERVER_MAX,
  parameter logic [15:0] IVL_MAX    = `MBCFG_IVL_MAX
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // decoded request from the frame parser
  input  wire logic                      req_valid,
  input  wire mbcfg_pkg::mbcfg_req_s     req,
  output var  logic                      req_ready_q,
  // answer to the frame builder
  output var  logic                      rsp_valid_q,
  output var  mbcfg_pkg::mbcfg_rsp_s     rsp_q,
  input  wire logic                      tx_done,
  // settings in force
  output var  mbcfg_pkg::mbcfg_serial_s  serial_q,
  output var  mbcfg_pkg::mbcfg_interval_s interval_q,
  // wind result
  input  wire logic                      wind_valid,
  input  wire logic [1:0]                wind_status,
  input  wire logic [31:0]               wind_value,
  output var  logic                      wind_report_valid_q,
  output var  logic [31:0]               wind_report_q
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (SERVER_MAX < `MBCFG_SERVER_MIN || SERVER_MAX > 16'h00FF) begin : g_chk_srv
    $error("SERVER_MAX outside 1..255");
  end
  if (IVL_MAX < `MBCFG_IVL_MIN) begin : g_chk_ivl
    $error("IVL_MAX below interval minimum");
  end
  // a reset value that the range check refuses could never be written back
  if (`MBCFG_RST_SERVER > SERVER_MAX) begin : g_chk_srv_rst
    $error("SERVER_MAX below the reset address");
  end
  if (`MBCFG_RST_WIND > IVL_MAX || `MBCFG_RST_HUMTMP > IVL_MAX
      || `MBCFG_RST_TILT > IVL_MAX) begin : g_chk_ivl_rst
    $error("IVL_MAX below a reset interval");
  end

  // ----------------------------------------------------------------
  // bank size
  // ----------------------------------------------------------------
  localparam int unsigned NUM_REGS = 7;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_index(input logic [15:0] addr);
    logic [2:0] idx;
    idx = `MBCFG_IDX_NONE;
    case (addr)
      `MBCFG_ADDR_SERVER: idx = `MBCFG_IDX_SERVER;
      `MBCFG_ADDR_BAUD:   idx = `MBCFG_IDX_BAUD;
      `MBCFG_ADDR_PARITY: idx = `MBCFG_IDX_PARITY;
      `MBCFG_ADDR_STOP:   idx = `MBCFG_IDX_STOP;
      `MBCFG_ADDR_WIND:   idx = `MBCFG_IDX_WIND;
      `MBCFG_ADDR_HUMTMP: idx = `MBCFG_IDX_HUMTMP;
      `MBCFG_ADDR_TILT:   idx = `MBCFG_IDX_TILT;
      default:            idx = `MBCFG_IDX_NONE;
    endcase
    return idx;
  endfunction

  function automatic logic [15:0] reset_value(input logic [2:0] idx);
    logic [15:0] v;
    v = 16'h0000;
    case (idx)
      `MBCFG_IDX_SERVER: v = `MBCFG_RST_SERVER;
      `MBCFG_IDX_BAUD:   v = `MBCFG_RST_BAUD;
      `MBCFG_IDX_PARITY: v = `MBCFG_RST_PARITY;
      `MBCFG_IDX_STOP:   v = `MBCFG_RST_STOP;
      `MBCFG_IDX_WIND:   v = `MBCFG_RST_WIND;
      `MBCFG_IDX_HUMTMP: v = `MBCFG_RST_HUMTMP;
      `MBCFG_IDX_TILT:   v = `MBCFG_RST_TILT;
      default:           v = 16'h0000;
    endcase
    return v;
  endfunction

  // the bank keeps full words, so range checks look at all 16 bits
  function automatic logic value_legal(input logic [2:0] idx, input logic [15:0] v);
    logic ok;
    ok = 1'b0;
    case (idx)
      `MBCFG_IDX_SERVER: ok = (v >= `MBCFG_SERVER_MIN) && (v <= SERVER_MAX);
      `MBCFG_IDX_BAUD:   ok = (v <= `MBCFG_BAUD_MAX);
      `MBCFG_IDX_PARITY: ok = (v <= `MBCFG_PARITY_MAX);
      // zero stop bits falls below the minimum
      `MBCFG_IDX_STOP:   ok = (v >= `MBCFG_STOP_MIN) && (v <= `MBCFG_STOP_MAX);
      `MBCFG_IDX_WIND,
      `MBCFG_IDX_HUMTMP,
      `MBCFG_IDX_TILT:   ok = (v >= `MBCFG_IVL_MIN) && (v <= IVL_MAX);
      default:           ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic is_serial(input logic [2:0] idx);
    logic s;
    s = 1'b0;
    case (idx)
      `MBCFG_IDX_SERVER,
      `MBCFG_IDX_BAUD,
      `MBCFG_IDX_PARITY,
      `MBCFG_IDX_STOP: s = 1'b1;
      default:         s = 1'b0;
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------
  // request classification
  // ----------------------------------------------------------------
  mbcfg_pkg::mbcfg_state_e state_q;
  mbcfg_pkg::mbcfg_state_e state_d;
  logic [15:0]             bank_q [NUM_REGS];
  logic [2:0]              idx;
  logic                    take;
  logic                    is_read;
  logic                    is_write;
  logic                    fc_bad;
  logic                    addr_bad;
  logic                    val_bad;
  logic                    wr_ok;
  logic                    serial_touch;
  logic                    swap_now;

  assign take     = req_valid && req_ready_q;
  assign idx      = reg_index(req.addr);
  assign is_read  = (req.func == `MBCFG_FC_RD_HOLD) || (req.func == `MBCFG_FC_RD_INPUT);
  assign is_write = (req.func == `MBCFG_FC_WR_SINGLE);
  assign fc_bad   = !is_read && !is_write;
  assign addr_bad = (idx == `MBCFG_IDX_NONE);
  assign val_bad  = is_write && !value_legal(idx, req.data);
  assign wr_ok    = take && is_write && !addr_bad && !val_bad;
  assign serial_touch = is_serial(idx);
  assign swap_now     = (state_q == mbcfg_pkg::MBCFG_ST_SWAP) && tx_done;

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  // a write lands only once every check passed, so a refused one keeps the old word
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_bank
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        bank_q[g] <= reset_value(3'(g));
      end else if (wr_ok && idx == 3'(g)) begin
        bank_q[g] <= req.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= take;
    end
  end

  // exceptions keep the request's address so the client can match them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_q <= '0;
    end else if (take) begin
      rsp_q.addr <= req.addr;
      if (fc_bad) begin
        rsp_q.func <= req.func | `MBCFG_FC_EXC_BIT;
        rsp_q.data <= {8'h00, `MBCFG_EXC_FUNC};
      end else if (addr_bad) begin
        rsp_q.func <= req.func | `MBCFG_FC_EXC_BIT;
        rsp_q.data <= {8'h00, `MBCFG_EXC_ADDR};
      end else if (val_bad) begin
        rsp_q.func <= req.func | `MBCFG_FC_EXC_BIT;
        rsp_q.data <= {8'h00, `MBCFG_EXC_VALUE};
      end else if (is_write) begin
        rsp_q.func <= req.func;
        rsp_q.data <= req.data;                  // echo of accepted write
      end else begin
        rsp_q.func <= req.func;
        rsp_q.data <= bank_q[idx];
      end
    end
  end

  // ----------------------------------------------------------------
  // serial settings swap
  // ----------------------------------------------------------------
  // the answer to a link write must leave under the old settings,
  // so the swap waits for the builder's tx_done
  always_comb begin
    state_d = state_q;
    case (state_q)
      mbcfg_pkg::MBCFG_ST_LIVE: begin
        if (wr_ok && serial_touch) begin
          state_d = mbcfg_pkg::MBCFG_ST_SWAP;
        end
      end
      mbcfg_pkg::MBCFG_ST_SWAP: begin
        if (tx_done) begin
          state_d = mbcfg_pkg::MBCFG_ST_LIVE;
        end
      end
      default: state_d = mbcfg_pkg::MBCFG_ST_LIVE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= mbcfg_pkg::MBCFG_ST_LIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // requests held off while a swap is pending
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_ready_q <= 1'b0;
    end else begin
      // no back-to-back takes: ready drops for the answer cycle
      req_ready_q <= (state_d == mbcfg_pkg::MBCFG_ST_LIVE) && !take;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_q.server_address  <= 8'(`MBCFG_RST_SERVER);
      serial_q.baud_select     <= 1'(`MBCFG_RST_BAUD);
      serial_q.parity_format   <= 2'(`MBCFG_RST_PARITY);
      serial_q.stop_bit_format <= 2'(`MBCFG_RST_STOP);
    end else if (swap_now) begin
      // only low bits of a legal value matter to the link
      serial_q.server_address  <= bank_q[`MBCFG_IDX_SERVER][7:0];
      serial_q.baud_select     <= bank_q[`MBCFG_IDX_BAUD][0];
      serial_q.parity_format   <= bank_q[`MBCFG_IDX_PARITY][1:0];
      serial_q.stop_bit_format <= bank_q[`MBCFG_IDX_STOP][1:0];
    end
  end

  // intervals may change at once, they do not touch the link
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      interval_q.wind_interval          <= `MBCFG_RST_WIND;
      interval_q.humidity_temp_interval <= `MBCFG_RST_HUMTMP;
      interval_q.tilt_interval          <= `MBCFG_RST_TILT;
    end else begin
      interval_q.wind_interval          <= bank_q[`MBCFG_IDX_WIND];
      interval_q.humidity_temp_interval <= bank_q[`MBCFG_IDX_HUMTMP];
      interval_q.tilt_interval          <= bank_q[`MBCFG_IDX_TILT];
    end
  end

  // ----------------------------------------------------------------
  // wind result substitution
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wind_report_valid_q <= 1'b0;
    end else begin
      wind_report_valid_q <= wind_valid;
    end
  end

  // the report keeps the last result until the next one arrives
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wind_report_q <= 32'h00000000;
    end else begin
      if (wind_valid) begin
        case (wind_status)
          `MBCFG_WIND_OK:    wind_report_q <= wind_value;
          `MBCFG_WIND_F9990: wind_report_q <= `MBCFG_SENT_9990;
          `MBCFG_WIND_F9999: wind_report_q <= `MBCFG_SENT_9999;
          `MBCFG_WIND_F7999: wind_report_q <= `MBCFG_SENT_7999;
          default:           wind_report_q <= `MBCFG_SENT_9999;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== dv/mbcfg_holding_monitor.sv ====
`include "mbcfg_regs.svh"
`default_nettype none

module mbcfg_holding_monitor #(
  parameter logic [15:0] SERVER_MAX = `MBCFG_SERVER_MAX,
  parameter logic [15:0] IVL_MAX    = `MBCFG_IVL_MAX
) (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       rst_n,
  // request and answer
  input wire logic                       req_valid,
  input wire mbcfg_pkg::mbcfg_req_s      req,
  input wire logic                       req_ready_q,
  input wire logic                       rsp_valid_q,
  input wire mbcfg_pkg::mbcfg_rsp_s      rsp_q,
  input wire logic                       tx_done,
  // settings and wind
  input wire mbcfg_pkg::mbcfg_serial_s   serial_q,
  input wire mbcfg_pkg::mbcfg_interval_s interval_q,
  input wire logic                       wind_valid,
  input wire logic [1:0]                 wind_status,
  input wire logic [31:0]                wind_value,
  input wire logic                       wind_report_valid_q,
  input wire logic [31:0]                wind_report_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic take = req_valid && req_ready_q;

  take_answer_a: assert property (take |=> rsp_valid_q && !req_ready_q)
    else $error("no answer one cycle after a take");
  rsp_cause_a: assert property (rsp_valid_q |-> $past(take) ##1 !rsp_valid_q)
    else $error("answer without a take or longer than one cycle");
  read_echo_a: assert property (rsp_valid_q && !rsp_q.func[7] |->
    rsp_q.func inside {8'h03, 8'h04, 8'h06} && rsp_q.addr == $past(req.addr))
    else $error("normal answer with wrong code or address");
  exc_format_a: assert property (rsp_valid_q && rsp_q.func[7] |->
    rsp_q.data inside {16'h0001, 16'h0002, 16'h0003} && rsp_q.func[6:0] == $past(req.func[6:0]))
    else $error("malformed exception answer");
  reset_vals_a: assert property ($rose(rst_n) |-> !rsp_valid_q && !req_ready_q &&
    serial_q == {8'h01, 1'b1, 2'h2, 2'h1} && interval_q == {16'h0003, 16'h000A, 16'h003C})
    else $error("wrong settings after reset");
  serial_range_a: assert property (serial_q.server_address != 8'h00 &&
    {8'h00, serial_q.server_address} <= SERVER_MAX && serial_q.parity_format != 2'h3 &&
    serial_q.stop_bit_format inside {2'h1, 2'h2})
    else $error("serial setting out of range");
  ivl_range_a: assert property (interval_q.wind_interval inside {[16'h0001:IVL_MAX]} &&
    interval_q.humidity_temp_interval inside {[16'h0001:IVL_MAX]} &&
    interval_q.tilt_interval inside {[16'h0001:IVL_MAX]})
    else $error("interval out of range");
  serial_swap_a: assert property (!$stable(serial_q) |-> $past(tx_done))
    else $error("serial settings changed before the answer went out");
  wind_sent_a: assert property (wind_valid |=> wind_report_valid_q && wind_report_q ==
    ($past(wind_status) == 2'h0 ? $past(wind_value) : $past(wind_status) == 2'h1 ?
    32'hC61C1800 : $past(wind_status) == 2'h2 ? 32'hC61C3C00 : 32'hC5F9F800))
    else $error("wind report wrong or late");

  exc_seen_c: cover property (rsp_valid_q && rsp_q.func[7]);
  swap_seen_c: cover property (tx_done ##1 !$stable(serial_q));
  sent_seen_c: cover property (wind_valid && wind_status == 2'h3);
endmodule

bind mbcfg_holding_regs mbcfg_holding_monitor #(.SERVER_MAX(SERVER_MAX), .IVL_MAX(IVL_MAX)) u_mon (
  .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready_q(req_ready_q),
  .rsp_valid_q(rsp_valid_q), .rsp_q(rsp_q), .tx_done(tx_done), .serial_q(serial_q),
  .interval_q(interval_q), .wind_valid(wind_valid), .wind_status(wind_status),
  .wind_value(wind_value), .wind_report_valid_q(wind_report_valid_q),
  .wind_report_q(wind_report_q));

`default_nettype wire

// ==== dv/mbcfg_client_model.sv ====
`default_nettype none

module mbcfg_client_model (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // request side
  output var  logic                  req_valid,
  output var  mbcfg_pkg::mbcfg_req_s req,
  input  wire logic                  req_ready_q,
  // answer side
  input  wire logic                  rsp_valid_q,
  output var  logic                  tx_done,
  input  wire logic [3:0]            tx_gap
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_valid = 1'b0;
    req = '0;
    tx_done = 1'b0;
  end

  // one request at a time, held until a ready edge; waits out a settings swap
  task automatic send(input mbcfg_pkg::mbcfg_req_s r);
    @(negedge clk);
    req_valid = 1'b1;
    req = r;
    for (int n = 0; n < 64 && !req_ready_q; n++) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    req = ~r;
  endtask

  // frame builder: answer leaves the wire some cycles later
  initial forever begin
    @(negedge clk);
    if (rst_n && rsp_valid_q) begin
      repeat (tx_gap) @(negedge clk);
      tx_done = 1'b1;
      @(negedge clk);
      tx_done = 1'b0;
    end
  end
endmodule

`default_nettype wire

// ==== dv/tb_top.sv ====
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       clk, rst_n, req_valid, req_ready_q, rsp_valid_q, tx_done;
  logic                       wind_valid, wind_report_valid_q;
  logic [1:0]                 wind_status;
  logic [31:0]                wind_value, wind_report_q, seed, r, cycles, exw;
  logic [3:0]                 tx_gap;
  mbcfg_pkg::mbcfg_req_s      req;
  mbcfg_pkg::mbcfg_rsp_s      rsp_q, exp_rsp;
  mbcfg_pkg::mbcfg_serial_s   serial_q;
  mbcfg_pkg::mbcfg_interval_s interval_q;
  mbcfg_pkg::mbcfg_rsp_s      rq[$];
  logic [31:0]                wq[$];
  logic [15:0]                bank [7];
  int                         error_cnt, num_checks;
  // last entry is deliberately unmapped
  localparam logic [15:0] ADDRS [8] = '{16'h1130, 16'h1131, 16'h1132, 16'h1133,
                                        16'h1194, 16'h1195, 16'h1196, 16'h1134};
  localparam logic [7:0]  LO [7] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01};
  localparam logic [7:0]  HI [7] = '{8'hF7, 8'h01, 8'h02, 8'h02, 8'h78, 8'h78, 8'h78};
  localparam logic [7:0]  RSTV [7] = '{8'h01, 8'h01, 8'h02, 8'h01, 8'h03, 8'h0A, 8'h3C};

  mbcfg_holding_regs DUT (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q), .rsp_q(rsp_q), .tx_done(tx_done),
    .serial_q(serial_q), .interval_q(interval_q), .wind_valid(wind_valid),
    .wind_status(wind_status), .wind_value(wind_value),
    .wind_report_valid_q(wind_report_valid_q), .wind_report_q(wind_report_q));
  mbcfg_client_model u_cli (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q), .tx_done(tx_done), .tx_gap(tx_gap));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // note the expected answer, send, then wait until the frame has gone out
  task automatic op(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    mbcfg_pkg::mbcfg_rsp_s e;
    int i;
    i = 7;
    for (int k = 0; k < 7; k++) if (ADDRS[k] == a) i = k;
    e = '{f, a, d};
    if (f != 8'h03 && f != 8'h04 && f != 8'h06) e = '{f | 8'h80, a, 16'h0001};
    else if (i == 7) e = '{f | 8'h80, a, 16'h0002};
    else if (f != 8'h06) e.data = bank[i];
    else if (d < LO[i] || d > HI[i]) e = '{f | 8'h80, a, 16'h0003};
    else bank[i] = d;
    rq.push_back(e);
    tx_gap = 4'(rnd() % 7);
    u_cli.send('{f, a, d});
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      if (tx_done === 1'b1) break;
    end
    @(negedge clk);
    `CHK("serial_q", {bank[0][7:0], bank[1][0], bank[2][1:0], bank[3][1:0]}, serial_q)
    `CHK("interval_q", {bank[4], bank[5], bank[6]}, interval_q)
  endtask

  // reset, then read every register back once, even indices with code 03 and odd ones with code 04
  task automatic restart();
    rst_n = 1'b0;
    for (int k = 0; k < 7; k++) bank[k] = {8'h00, RSTV[k]};
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    for (int k = 0; k < 7; k++) op(k[0] ? 8'h04 : 8'h03, ADDRS[k], 16'h0000);
  endtask

  always @(negedge clk) if (rst_n) begin
    if (rsp_valid_q === 1'b1) begin
      exp_rsp = rq.pop_front();
      if (exp_rsp.func[7]) begin
        `CHK("exception", exp_rsp, rsp_q)
      end else begin
        `CHK("answer", exp_rsp, rsp_q)
      end
    end
    if (wind_report_valid_q === 1'b1) begin
      exw = wq.pop_front();
      `CHK("wind_report_q", exw, wind_report_q)
    end
  end

  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles == 8000) begin
        error_cnt++;
        report_and_stop();
      end
    end
  end

  initial begin
    seed = 32'h0000F53A;
    {wind_valid, wind_status, wind_value, tx_gap, error_cnt, num_checks} = '0;
    restart();
    op(8'h10, 16'h1130, 16'h0005);
    op(8'h05, 16'h1194, 16'h0005);
    op(8'h03, 16'h1134, 16'h0000);
    op(8'h06, 16'h1132, 16'h0001);
    for (int k = 0; k < 7; k++) begin
      op(8'h06, ADDRS[k], 16'(LO[k]) - 16'h0001);
      op(8'h06, ADDRS[k], 16'(HI[k]) + 16'h0001);
      op(8'h06, ADDRS[k], 16'(HI[k]));
      op(8'h04, ADDRS[k], 16'h0000);
      op(8'h06, ADDRS[k], 16'(LO[k]));
    end
    for (int n = 0; n < 40; n++) begin
      r = rnd();
      op(r[2:0] == 3'h7 ? 8'h2B : r[1] ? 8'h06 : r[0] ? 8'h04 : 8'h03, ADDRS[r[10:8]],
         16'(r[16] ? r[31:20] % 300 : r[31:20] % 4));
    end
    restart();
    for (int n = 0; n < 8; n++) begin
      r = rnd();
      wq.push_back(n[1:0] == 2'h0 ? r : n[1:0] == 2'h1 ? 32'hC61C1800 :
                   n[1:0] == 2'h2 ? 32'hC61C3C00 : 32'hC5F9F800);
      @(negedge clk);
      wind_valid = 1'b1;
      wind_status = n[1:0];
      wind_value = r;
    end
    @(negedge clk);
    wind_valid = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("pending answers", 32'h0, 32'(rq.size() + wq.size()))
    report_and_stop();
  end
endmodule

`default_nettype wire
